/* File: hw/orient_regs.vh */
// Purpose: constants for the spindle orientation and position hold block
// Assumes: 100 MHz sys_clk, classic Wishbone slave with 32-bit data
// Notes:   register offsets are byte addresses of aligned words
`ifndef ORIENT_REGS_VH
`define ORIENT_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL        8'h00
`define OFS_GAIN        8'h04
`define OFS_OFFSET      8'h08
`define OFS_TARGET      8'h0C
`define OFS_DIVISOR     8'h10
`define OFS_THRESH      8'h14
`define OFS_STATUS      8'h18
`define OFS_POS_TOTAL   8'h1C
`define OFS_POS_DIV     8'h20
`define OFS_INDEX_POS   8'h24
`define OFS_ERROR       8'h28
`define OFS_RATE        8'h2C

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_GATE_BIT   0
`define CTRL_MODE_BIT   1
`define ST_ACTIVE_BIT   0
`define ST_REACHED_BIT  1
`define ST_SEEK_BIT     2

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_CTRL        2'h0
`define RST_GAIN        16'h0000
`define RST_OFFSET      16'h0000
`define RST_TARGET      16'h0000
`define RST_DIVISOR     15'h0001
`define RST_THRESH      16'h0100

// ----------------------------------------
// limits and timing
// ----------------------------------------
`define TARGET_MAX      16'h7530
`define DIVISOR_MAX     15'h7530
`define REACH_WINDOW    32'h0000000A
`define CLK_HZ          100000000
`define SETTLE_MS       400
`define SETTLE_CYCLES   ((`CLK_HZ / 1000) * `SETTLE_MS)
`define RATE_GATE_CYCLES 32'h05F5E100

`endif

/* File: hw/pos_divider.v */
// Purpose: divides the running total for a slow-polling host
// Assumes: divisor between 1 and 30000, clamped by the caller
// Notes:   serial restoring divide, a result every 33 cycles
`timescale 1ns/1ps
`include "orient_regs.vh"

module pos_divider (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rst_b,
	// operands
	input  wire [31:0] dividend,
	input  wire [14:0] divisor,
	// quotient, signed like the dividend
	output reg  [31:0] quotient
);

	reg  [5:0]  bit_reg;
	reg  [31:0] num_reg;
	reg  [31:0] rem_reg;
	reg  [31:0] quo_reg;
	reg         neg_reg;
	wire [31:0] trial;

	assign trial = {rem_reg[30:0], num_reg[31]};

	// one quotient bit per cycle, magnitude then sign
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_reg  <= 6'h00;
			num_reg  <= 32'h00000000;
			rem_reg  <= 32'h00000000;
			quo_reg  <= 32'h00000000;
			neg_reg  <= 1'b0;
			quotient <= 32'h00000000;
		end else if (bit_reg == 6'h00) begin
			neg_reg <= dividend[31];
			num_reg <= dividend[31] ? (32'h00000000 - dividend) : dividend;
			rem_reg <= 32'h00000000;
			quo_reg <= 32'h00000000;
			bit_reg <= 6'h20;
		end else begin
			num_reg <= {num_reg[30:0], 1'b0};
			if (trial >= {17'h00000, divisor}) begin
				rem_reg <= trial - {17'h00000, divisor};
				quo_reg <= {quo_reg[30:0], 1'b1};
			end else begin
				rem_reg <= trial;
				quo_reg <= {quo_reg[30:0], 1'b0};
			end
			bit_reg <= bit_reg - 6'h01;
			if (bit_reg == 6'h01) begin
				if (neg_reg)
					quotient <= 32'h00000000 - {quo_reg[30:0], (trial >= {17'h00000, divisor})};
				else
					quotient <= {quo_reg[30:0], (trial >= {17'h00000, divisor})};
			end
		end
	end

endmodule

/* File: hw/quad_counter.v */
// Purpose: bidirectional encoder count with index latch
// Assumes: encoder and index inputs already synchronised to sys_clk
// Notes:   pulse mode counts both edges of the pulse line, two per line
`timescale 1ns/1ps
`include "orient_regs.vh"

module quad_counter (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rst_b,
	// encoder lines, synchronised
	input  wire        enc_a,
	input  wire        enc_b,
	input  wire        index_in,
	input  wire        pulse_mode,
	input  wire        gate_en,
	// results
	output reg  [31:0] pos_count,
	output reg  [31:0] index_pos,
	output reg         index_seen
);

	reg         a_reg;
	reg         b_reg;
	reg         idx_reg;
	reg  [31:0] step;

	// quadrature decode: any edge counts, direction from phase
	always @* begin
		step = 32'h00000000;
		if (pulse_mode) begin
			if (a_reg != enc_a)
				step = enc_b ? 32'hFFFFFFFF : 32'h00000001;
		end else if ((a_reg != enc_a) || (b_reg != enc_b)) begin
			step = ((a_reg ^ enc_b) ? 32'h00000001 : 32'hFFFFFFFF);
		end
	end

	// counter and index capture on rising edge while gate open
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			a_reg      <= 1'b0;
			b_reg      <= 1'b0;
			idx_reg    <= 1'b0;
			pos_count  <= 32'h00000000;
			index_pos  <= 32'h00000000;
			index_seen <= 1'b0;
		end else begin
			a_reg     <= enc_a;
			b_reg     <= enc_b;
			idx_reg   <= index_in;
			pos_count <= pos_count + step;
			index_seen <= 1'b0;
			if (index_in && !idx_reg && gate_en) begin
				index_pos  <= pos_count + step;
				index_seen <= 1'b1;
			end
		end
	end

endmodule

/* File: hw/spindle_orient_position_lock.v */
// Purpose: spindle orientation and zero-speed position hold
// Assumes: speed demand and feedback arrive as signed words on sys_clk;
//          encoder and index pins are asynchronous and are synchronised here
// Notes:   classic Wishbone slave, single-cycle registered ack
//
// Summary of operation
// - orientation starts after demand and feedback stay low 400 ms
// - index seek needs non-zero gain and the index gate open
// - once engaged, demand above threshold or zero gain releases the loop
// - above threshold no position action, target writes still accepted
// - reference is index position latched before speed fell low
// - index offset sampled once at orientation start
// - offset and target are signed; offset sign picks seek direction
// - shaft goes straight to target relative to offset
// - new target while active is sought at once, repeatedly
// - reached flag rises on each arrival at current target
// - gain sets loop response; zero gain switches loop off
// - gate closed: no orientation or meter, hold where stopped
// - index rate meter runs at any speed while gate open
// - total counts four per line quadrature, two pulse mode
// - host position is total divided by divisor 1 to 30000
// - index position captured on rising index edge
// - target is signed, limited to plus/minus 30000, default 0
// - counter follows rotation direction up or down
// - error is target minus count, drive reduces error
// - reached flag high while absolute error below ten counts
//
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "orient_regs.vh"

module spindle_orient_position_lock (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rst_b,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// drive speed signals
	input  wire [15:0] speed_demand,
	input  wire [15:0] speed_feedback,
	// encoder pins
	input  wire        enc_a_pin,
	input  wire        enc_b_pin,
	input  wire        index_input_terminal,
	// outputs
	output reg  [31:0] speed_correction,
	output reg         loop_active,
	output reg         target_reached_flag
);

	// ----------------------------------------
	// state codes
	// ----------------------------------------
	localparam ST_IDLE   = 2'h0;
	localparam ST_SETTLE = 2'h1;
	localparam ST_HOLD   = 2'h2;

	// absolute value of a signed speed word
	function [15:0] abs16;
		input [15:0] v;
		begin
			abs16 = v[15] ? (16'h0000 - v) : v;
		end
	endfunction

	// clamp signed word to plus/minus limit
	function [15:0] clamp16;
		input [15:0] v;
		input [15:0] lim;
		begin
			if (!v[15] && (v > lim))
				clamp16 = lim;
			else if (v[15] && ((16'h0000 - v) > lim))
				clamp16 = 16'h0000 - lim;
			else
				clamp16 = v;
		end
	endfunction

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	reg  [2:0]  sync1_reg;
	reg  [2:0]  sync2_reg;

	// two flops before anything reads a pin
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else begin
			sync1_reg <= {index_input_terminal, enc_b_pin, enc_a_pin};
			sync2_reg <= sync1_reg;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg  [1:0]  ctrl_reg;
	reg  [15:0] gain_reg;
	reg  [15:0] offset_reg;
	reg  [15:0] target_reg;
	reg  [14:0] divisor_reg;
	reg  [15:0] thresh_reg;
	reg  [31:0] rate_reg;
	wire        gate_en;
	wire        pulse_mode;
	wire [31:0] pos_count;
	wire [31:0] index_pos;
	wire        index_seen;
	wire [31:0] pos_div;
	wire        wb_req;
	reg  [1:0]  state_reg;
	reg  [31:0] ref_reg;
	reg  [31:0] ref_idx_reg;
	reg  [31:0] error_reg;
	reg  [31:0] timer_reg;
	reg         seek_reg;

	assign gate_en    = ctrl_reg[`CTRL_GATE_BIT];
	assign pulse_mode = ctrl_reg[`CTRL_MODE_BIT];
	assign wb_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// register writes, target and divisor clamped on entry; target writable at any speed
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg    <= `RST_CTRL;
			gain_reg    <= `RST_GAIN;
			offset_reg  <= `RST_OFFSET;
			target_reg  <= `RST_TARGET;
			divisor_reg <= `RST_DIVISOR;
			thresh_reg  <= `RST_THRESH;
		end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_sel_i[1]) begin
			case (wb_adr_i)
				`OFS_CTRL:    ctrl_reg   <= wb_dat_i[1:0];
				`OFS_GAIN:    gain_reg   <= wb_dat_i[15:0];
				`OFS_OFFSET:  offset_reg <= wb_dat_i[15:0];
				`OFS_TARGET:  target_reg <= clamp16(wb_dat_i[15:0], `TARGET_MAX);
				`OFS_DIVISOR: begin
					if (wb_dat_i[14:0] == 15'h0000)
						divisor_reg <= `RST_DIVISOR;
					else if (wb_dat_i[14:0] > `DIVISOR_MAX)
						divisor_reg <= `DIVISOR_MAX;
					else
						divisor_reg <= wb_dat_i[14:0];
				end
				`OFS_THRESH:  thresh_reg <= wb_dat_i[15:0];
				default:      ctrl_reg   <= ctrl_reg;
			endcase
		end
	end

	// read mux and single-cycle ack; unmapped reads give zero
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`OFS_CTRL:      wb_dat_o <= {30'h00000000, ctrl_reg};
					`OFS_GAIN:      wb_dat_o <= {16'h0000, gain_reg};
					`OFS_OFFSET:    wb_dat_o <= {16'h0000, offset_reg};
					`OFS_TARGET:    wb_dat_o <= {16'h0000, target_reg};
					`OFS_DIVISOR:   wb_dat_o <= {17'h00000, divisor_reg};
					`OFS_THRESH:    wb_dat_o <= {16'h0000, thresh_reg};
					`OFS_STATUS:    wb_dat_o <= {29'h00000000, seek_reg,
						target_reached_flag, loop_active};
					`OFS_POS_TOTAL: wb_dat_o <= pos_count;
					`OFS_POS_DIV:   wb_dat_o <= pos_div;
					`OFS_INDEX_POS: wb_dat_o <= index_pos;
					`OFS_ERROR:     wb_dat_o <= error_reg;
					`OFS_RATE:      wb_dat_o <= rate_reg;
					default:        wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// encoder count and host divide
	// ----------------------------------------
	quad_counter u_count (
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.enc_a      (sync2_reg[0]),
		.enc_b      (sync2_reg[1]),
		.index_in   (sync2_reg[2]),
		.pulse_mode (pulse_mode),
		.gate_en    (gate_en),
		.pos_count  (pos_count),
		.index_pos  (index_pos),
		.index_seen (index_seen)
	);

	pos_divider u_div (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.dividend (pos_count),
		.divisor  (divisor_reg),
		.quotient (pos_div)
	);

	// ----------------------------------------
	// index rate meter
	// ----------------------------------------
	reg  [31:0] gate_cnt_reg;
	reg  [31:0] edge_cnt_reg;

	// edges per one-second window; idle and zero while gate closed
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			gate_cnt_reg <= 32'h00000000;
			edge_cnt_reg <= 32'h00000000;
			rate_reg     <= 32'h00000000;
		end else if (!gate_en) begin
			gate_cnt_reg <= 32'h00000000;
			edge_cnt_reg <= 32'h00000000;
			rate_reg     <= 32'h00000000;
		end else if (gate_cnt_reg == `RATE_GATE_CYCLES - 32'h00000001) begin
			gate_cnt_reg <= 32'h00000000;
			edge_cnt_reg <= 32'h00000000;
			rate_reg     <= edge_cnt_reg + {31'h00000000, index_seen};
		end else begin
			gate_cnt_reg <= gate_cnt_reg + 32'h00000001;
			edge_cnt_reg <= edge_cnt_reg + {31'h00000000, index_seen};
		end
	end

	// ----------------------------------------
	// low-speed detection and loop sequencing
	// ----------------------------------------
	wire        dem_low;
	wire        fb_low;
	wire [31:0] offset_ext;
	wire [31:0] target_ext;
	wire [31:0] goal;
	wire [31:0] err_next;
	wire [31:0] err_abs;

	assign dem_low    = abs16(speed_demand) < thresh_reg;
	assign fb_low     = abs16(speed_feedback) < thresh_reg;
	assign offset_ext = {{16{offset_reg[15]}}, offset_reg};
	assign target_ext = {{16{target_reg[15]}}, target_reg};
	// live target on top of the frozen reference
	assign goal       = seek_reg ? (ref_reg + target_ext) : ref_reg;
	assign err_next   = goal - pos_count;
	assign err_abs    = err_next[31] ? (32'h00000000 - err_next) : err_next;

	// index reference kept only while running above threshold
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			ref_idx_reg <= 32'h00000000;
		else if (index_seen && (state_reg != ST_HOLD) && !(dem_low && fb_low))
			ref_idx_reg <= index_pos;
	end

	// timer, engage and release
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_IDLE;
			timer_reg <= 32'h00000000;
			ref_reg   <= 32'h00000000;
			seek_reg  <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					timer_reg <= 32'h00000000;
					if (dem_low && fb_low && (gain_reg != 16'h0000))
						state_reg <= ST_SETTLE;
				end
				ST_SETTLE: begin
					if (!(dem_low && fb_low) || (gain_reg == 16'h0000)) begin
						state_reg <= ST_IDLE;
					end else if (timer_reg == `SETTLE_CYCLES - 1) begin
						state_reg <= ST_HOLD;
						if (gate_en) begin
							// signed offset sets the seek side
							ref_reg  <= ref_idx_reg + offset_ext;
							seek_reg <= 1'b1;
						end else begin
							ref_reg  <= pos_count;
							seek_reg <= 1'b0;
						end
					end else begin
						timer_reg <= timer_reg + 32'h00000001;
					end
				end
				ST_HOLD: begin
					if (!dem_low || (gain_reg == 16'h0000)) begin
						state_reg <= ST_IDLE;
						seek_reg  <= 1'b0;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// loop output, error and reached flag; all zero when not holding
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			error_reg           <= 32'h00000000;
			speed_correction    <= 32'h00000000;
			loop_active         <= 1'b0;
			target_reached_flag <= 1'b0;
		end else if (state_reg == ST_HOLD) begin
			error_reg           <= err_next;
			// product truncated to 32 bits; large gains saturate externally
			speed_correction    <= err_next * {16'h0000, gain_reg};
			loop_active         <= 1'b1;
			target_reached_flag <= err_abs < `REACH_WINDOW;
		end else begin
			error_reg           <= 32'h00000000;
			speed_correction    <= 32'h00000000;
			loop_active         <= 1'b0;
			target_reached_flag <= 1'b0;
		end
	end

endmodule

/* File: verif/orient_checker.sv */
// Purpose: port checks for the orientation block
// Assumes: single clock, rst_b async active low
// Notes:   hold entry needs the full settle time, rarely seen in short runs
`timescale 1ns/1ps
`include "orient_regs.vh"

module orient_checker (
	// clock and reset
	input wire        sys_clk,
	input wire        rst_b,
	// bus
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	// hold outputs
	input wire [31:0] speed_correction,
	input wire        loop_active,
	input wire        target_reached_flag
);
	// ----
	// cycles since reset
	// ----
	reg  [31:0] since_rst_reg;
	wire        settled;

	// saturates so a long run cannot wrap back to early
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			since_rst_reg <= 32'h0;
		else if (since_rst_reg != 32'hFFFFFFFF)
			since_rst_reg <= since_rst_reg + 32'h1;
	end
	// one cycle of slack for the registered outputs
	assign settled = since_rst_reg >= (`SETTLE_CYCLES - 1);

	// ----
	// properties
	// ----
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	a_bus_handshake: assert property (s_taken |=> s_ack_pulse)
		else $error("request without single ack");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_rdata_holds: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
		else $error("read data moved outside a read");
	a_settle_first: assert property ($rose(loop_active) |-> settled)
		else $error("hold engaged before settle time");
	a_early_quiet: assert property (!settled |-> speed_correction == 32'h0)
		else $error("correction before settle time");
	a_corr_idle: assert property (!loop_active |-> speed_correction == 32'h0)
		else $error("correction outside hold");
	a_reached_hold: assert property (target_reached_flag |-> loop_active)
		else $error("reached flag outside hold");
	a_flag_release: assert property ($fell(loop_active) |-> !target_reached_flag)
		else $error("reached flag after release");
endmodule

bind spindle_orient_position_lock orient_checker chk_u (.sys_clk, .rst_b, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .speed_correction, .loop_active,
	.target_reached_flag);

/* File: verif/shaft_encoder_model.sv */
// Purpose: incremental shaft encoder with index pulse
// Assumes: lines change just after a rising clock edge
// Notes:   slow steps so the pin synchronisers never miss an edge
`timescale 1ns/1ps

module shaft_encoder_model (
	// clock
	input wire   sys_clk,
	// encoder pins
	output logic enc_a,
	output logic enc_b,
	output logic index_out
);
	logic [1:0] phase_reg;

	// encoder at rest on a line boundary
	initial begin
		enc_a = 1'b0;
		enc_b = 1'b0;
		index_out = 1'b0;
		phase_reg = 2'h0;
	end

	// gray walk, four states per line
	task automatic quad_lines(input int lines, input bit up);
		int n;
		for (n = 0; n < 4 * lines; n++) begin
			repeat (4) @(posedge sys_clk);
			phase_reg = up ? phase_reg + 2'h1 : phase_reg - 2'h1;
			enc_a <= phase_reg[1];
			enc_b <= phase_reg[1] ^ phase_reg[0];
		end
	endtask

	// direction on b, two a edges per line
	task automatic pulse_lines(input int lines, input bit down);
		int n;
		@(posedge sys_clk);
		enc_b <= down;
		for (n = 0; n < 2 * lines; n++) begin
			repeat (4) @(posedge sys_clk);
			enc_a <= !enc_a;
		end
	endtask

	// index level, held well past the sync delay
	task automatic index_level(input bit v);
		@(posedge sys_clk);
		index_out <= v;
		repeat (8) @(posedge sys_clk);
	endtask
endmodule

/* File: verif/testbench.sv */
// Purpose: self-checking bench for the orientation block
// Assumes: classic Wishbone, one-cycle registered ack
// Notes:   the 400 ms settle is too long to reach here
`timescale 1ns/1ps
`include "orient_regs.vh"

module testbench;
	logic        sys_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd, speed_correction;
	logic [15:0] speed_demand, speed_feedback;
	logic        enc_a, enc_b, idx, loop_active, target_reached_flag;
	int          miscompares = 0;
	int          comparisons = 0;

	spindle_orient_position_lock dut_u (.sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .speed_demand,
		.speed_feedback, .enc_a_pin(enc_a), .enc_b_pin(enc_b),
		.index_input_terminal(idx), .speed_correction, .loop_active, .target_reached_flag);
	shaft_encoder_model enc_u (.sys_clk, .enc_a, .enc_b, .index_out(idx));

	// 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input [31:0] seen, input [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// one classic cycle, held until ack is sampled
	task automatic wb(input [7:0] a, input bit we, input [31:0] d);
		int n;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			final_report();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic rchk(input [7:0] a, input [31:0] exp);
		wb(a, 1'b0, 32'h0);
		check(rd, exp);
	endtask

	task automatic t_reset_values;
		rchk(`OFS_CTRL, 32'h0);
		rchk(`OFS_GAIN, 32'h0);
		rchk(`OFS_TARGET, 32'h0);
		rchk(`OFS_DIVISOR, 32'h1);
		rchk(`OFS_THRESH, {16'h0, `RST_THRESH});
		rchk(`OFS_STATUS, 32'h0);
	endtask

	// clamps at both ends, unmapped place
	task automatic t_limits;
		wb(`OFS_TARGET, 1'b1, 32'h7918);
		rchk(`OFS_TARGET, 32'h7530);
		wb(`OFS_TARGET, 1'b1, 32'h86E8);
		wb(`OFS_TARGET, 1'b0, 32'h0);
		check({16'h0, rd[15:0]}, 32'h8AD0);
		wb(`OFS_DIVISOR, 1'b1, 32'h7FFF);
		rchk(`OFS_DIVISOR, 32'h7530);
		wb(`OFS_DIVISOR, 1'b1, 32'h0);
		rchk(`OFS_DIVISOR, 32'h1);
		wb(8'h30, 1'b1, 32'hFFFF);
		rchk(8'h30, 32'h0);
		// negative offset kept as a raw signed word
		wb(`OFS_OFFSET, 1'b1, 32'hFC18);
		rchk(`OFS_OFFSET, 32'hFC18);
		// write without the low byte lanes must be ignored
		wb_sel_i <= 4'hC;
		wb(`OFS_GAIN, 1'b1, 32'h55);
		wb_sel_i <= 4'hF;
		rchk(`OFS_GAIN, 32'h0);
	endtask

	// four per line, both directions
	task automatic t_quad;
		enc_u.quad_lines(10, 1'b1);
		enc_u.quad_lines(3, 1'b0);
		repeat (10) @(posedge sys_clk);
		rchk(`OFS_POS_TOTAL, 32'h1C);
	endtask

	// two per line in pulse mode
	task automatic t_pulse;
		wb(`OFS_CTRL, 1'b1, 32'h2);
		enc_u.pulse_lines(5, 1'b0);
		repeat (10) @(posedge sys_clk);
		rchk(`OFS_POS_TOTAL, 32'h26);
		enc_u.pulse_lines(2, 1'b1);
		repeat (10) @(posedge sys_clk);
		rchk(`OFS_POS_TOTAL, 32'h22);
	endtask

	// two updates of the serial divide per wait
	task automatic t_divider;
		wb(`OFS_DIVISOR, 1'b1, 32'h3);
		repeat (80) @(posedge sys_clk);
		rchk(`OFS_POS_DIV, 32'hB);
		wb(`OFS_DIVISOR, 1'b1, 32'h7530);
		repeat (80) @(posedge sys_clk);
		rchk(`OFS_POS_DIV, 32'h0);
	endtask

	// latch at the rise, not while high or at the fall
	task automatic t_index;
		wb(`OFS_CTRL, 1'b1, 32'h3);
		enc_u.index_level(1'b1);
		enc_u.pulse_lines(1, 1'b0);
		enc_u.index_level(1'b0);
		wb(`OFS_CTRL, 1'b1, 32'h2);
		rchk(`OFS_INDEX_POS, 32'h22);
		enc_u.index_level(1'b1);
		enc_u.index_level(1'b0);
		rchk(`OFS_INDEX_POS, 32'h22);
		rchk(`OFS_RATE, 32'h0);
		rchk(`OFS_POS_TOTAL, 32'h24);
	endtask

	// no action above threshold, brief low speed not enough
	task automatic t_no_hold;
		wb(`OFS_GAIN, 1'b1, 32'h10);
		wb(`OFS_TARGET, 1'b1, 32'h64);
		repeat (100) @(posedge sys_clk);
		check({31'h0, loop_active}, 32'h0);
		check(speed_correction, 32'h0);
		rchk(`OFS_STATUS, 32'h0);
		rchk(`OFS_TARGET, 32'h64);
		rchk(`OFS_ERROR, 32'h0);
		speed_demand <= 16'h0;
		speed_feedback <= 16'h0;
		repeat (200) @(posedge sys_clk);
		check({31'h0, loop_active}, 32'h0);
		speed_demand <= 16'h7FFF;
		speed_feedback <= 16'h7FFF;
	endtask

	// main sequence
	initial begin
		rst_b = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h0;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		speed_demand = 16'h7FFF;
		speed_feedback = 16'h7FFF;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_reset_values();
		t_limits();
		t_quad();
		t_pulse();
		t_divider();
		t_index();
		t_no_hold();
		final_report();
	end

	// hang guard
	initial begin
		repeat (50000) @(posedge sys_clk);
		miscompares++;
		final_report();
	end
endmodule
